//--- test/scg_count_sink_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Consumers of the generated count enable
// ****************************************************************
module scg_count_sink_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic timerXEn, // Timer X count enable
    input wire logic serialIoEn, // Serial unit count enable
    input wire logic uart0En, // UART 0 count enable
    input wire logic uart1En, // UART 1 count enable
    output logic [15:0] timerXTicks, // Ticks taken by Timer X
    output logic splitSeen // Consumers disagreed at some edge
);
    // One tick per enabled cycle; a split would let one consumer drift from the rest
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerXTicks <= 16'h0000;
            splitSeen <= 1'b0;
        end else begin
            if (timerXEn === 1'b1) begin
                timerXTicks <= timerXTicks + 16'h0001;
            end
            if ({serialIoEn, uart0En, uart1En} !== {3{timerXEn}}) begin
                splitSeen <= 1'b1;
            end
        end
    end
endmodule

//--- test/scg_count_source_gen_bench.sv
`timescale 1ns/10ps
`include "scg_defines.svh"

module scg_count_source_gen_bench;
    import scg_pkg::*;
    localparam logic [31:0] ADDR_A = {`SCG_HADDR_PAD, `SCG_IDX_PRESCALE, 2'h0};
    localparam logic [31:0] ADDR_B = {`SCG_HADDR_PAD, `SCG_IDX_DIVIDE, 2'h0};
    localparam logic [31:0] ADDR_M = {`SCG_HADDR_PAD, `SCG_IDX_MODE, 2'h0};
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, split;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic genClk, txEn, sioEn, u0En, u1En;
    logic [15:0] ticks;
    int error_cnt, cmp_count, pulseCnt, cycleCnt;

    // ****************************************************************
    // Clock, design and consumers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    assign hready = hreadyout; // Only slave on the bus
    scg_count_source_gen dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .generatedCountClock(genClk),
        .timerXCountEn(txEn), .serialIoCountEn(sioEn), .uart0CountEn(u0En),
        .uart1CountEn(u1En));
    scg_count_sink_model sink_u (.clk(clk), .rst_n(rst_n), .timerXEn(txEn),
        .serialIoEn(sioEn), .uart0En(u0En), .uart1En(u1En), .timerXTicks(ticks),
        .splitSeen(split));

    // Cycle and pulse counters, updated late so tasks read settled values
    always @(posedge clk) begin
        cycleCnt <= cycleCnt + 1;
        if (genClk === 1'b1) begin
            pulseCnt <= pulseCnt + 1;
        end
    end

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        error_cnt++;
        $display("timeout at %0t", $time);
        summarize();
    endtask

    // ****************************************************************
    // Bus master and pulse helpers
    // ****************************************************************
    task automatic waitReady();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) hang();
            @(posedge clk);
        end
    endtask

    // Writes at any moment are legal, counting or not
    task automatic busXfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
                           input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `SCG_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        r = hrdata;
        check({31'h0, hresp}, 32'h00000000);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        busXfer(a, 1'b1, `SCG_HSIZE_WORD, d, r);
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        busXfer(a, 1'b0, `SCG_HSIZE_WORD, 32'h00000000, r);
        check(r, e);
    endtask

    task automatic waitPulse();
        int n;
        n = 0;
        @(posedge clk);
        while (genClk !== 1'b1) begin
            n++;
            if (n > 2000) hang();
            @(posedge clk);
        end
    endtask

    // Two pulses are dropped first so the count reloads have settled
    task automatic span(input int n, input logic [31:0] exp);
        int t0;
        waitPulse();
        waitPulse();
        t0 = cycleCnt;
        repeat (n) waitPulse();
        check(cycleCnt - t0, exp);
    endtask

    task automatic quiet(input int n);
        int k;
        k = 0;
        repeat (n) begin
            @(posedge clk);
            if (genClk !== 1'b0) k++;
        end
        check(k, 32'h00000000);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic resetScenario();
        logic [31:0] r;
        rdChk(ADDR_A, 32'h000000FF);
        rdChk(ADDR_B, 32'h000000FF);
        rdChk(ADDR_M, 32'h00000000);
        rdChk(32'h000000C0, 32'h00000000);
        // A byte-wide write is refused and leaves the reset value
        busXfer(ADDR_A, 1'b1, 3'h0, 32'h00000055, r);
        rdChk(ADDR_A, 32'h000000FF);
        quiet(40);
    endtask

    task automatic loadScenario();
        wr(ADDR_A, 32'h00000012);
        rdChk(ADDR_A, 32'h00000012);
        wr(ADDR_B, 32'h00000034);
        rdChk(ADDR_B, 32'h00000034);
        wr(ADDR_M, 32'h00000005);
        wr(ADDR_A, 32'h00000056);
        rdChk(ADDR_A, 32'h00000012);
        wr(ADDR_B, 32'h00000078);
        rdChk(ADDR_B, 32'h00000034);
        wr(ADDR_M, 32'h000000F7);
        rdChk(ADDR_M, 32'h00000007);
        quiet(20);
        rdChk(ADDR_B, 32'h00000034);
    endtask

    task automatic rateScenario();
        logic [31:0] bv[3];
        bv = '{32'h00000000, 32'h00000003, 32'h00000007};
        wr(ADDR_M, 32'h0000000A);
        foreach (bv[i]) begin
            wr(ADDR_B, bv[i]);
            span(1, bv[i] + 32'h00000001);
        end
        @(posedge clk);
        check({31'h0, genClk}, 32'h00000000);
        rdChk(ADDR_A, 32'h00000012);
        wr(ADDR_M, 32'h00000008);
        wr(ADDR_A, 32'h00000002);
        wr(ADDR_B, 32'h00000001);
        span(2, 32'h00000006);
        wr(ADDR_A, 32'h00000003);
        wr(ADDR_B, 32'h00000002);
        span(3, 32'h0000000C);
        wr(ADDR_A, 32'h00000000);
        repeat (2) @(posedge clk);
        quiet(50);
    endtask

    task automatic liveWriteScenario();
        wr(ADDR_M, 32'h0000000E);
        wr(ADDR_B, 32'h00000003);
        span(1, 32'h00000004);
        wr(ADDR_B, 32'h00000001);
        span(1, 32'h00000002);
        wr(ADDR_M, 32'h00000009);
        wr(ADDR_A, 32'h00000001);
        span(1, 32'h00000004);
        check({16'h0000, ticks}, pulseCnt);
        check({31'h0, split}, 32'h00000000);
    endtask

    // Reset in mid-run; the second latch must come back as all ones, 256 clocks a pulse
    task automatic midResetScenario();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdChk(ADDR_A, 32'h000000FF);
        rdChk(ADDR_B, 32'h000000FF);
        rdChk(ADDR_M, 32'h00000000);
        quiet(20);
        wr(ADDR_M, 32'h0000000A);
        span(1, 32'h00000100);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h00000000;
        rst_n = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        pulseCnt = 0;
        cycleCnt = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        resetScenario();
        loadScenario();
        rateScenario();
        liveWriteScenario();
        midResetScenario();
        summarize();
    end
endmodule

//--- verilog/scg_count_source_gen.sv
`timescale 1ns/10ps
`include "scg_defines.svh"

// Overview of operation
// - Two 8-bit down counters, each with reload latch
// - Count pulse at zero underflows and reloads
// - Value n divides count source by n+1
// - Second counter counts clocks not eaten by first
// - Output rate is clk*A/(A+1)/(B+1)
// - First write: latch always; count unless deferred
// - Second write: latch always; count unless deferred
// - Stop bit halts first, bypasses clock to second
// - Output enable low stops both and output
// - Counters may be written at any time
// - Generated clock routed to timer, serial, UARTs
// - Reset: counters, latches all ones, mode zero

module scg_count_source_gen (
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic hsel, // AHB-Lite slave select
    input wire logic [31:0] haddr, // AHB-Lite address
    input wire logic [1:0] htrans, // AHB-Lite transfer type
    input wire logic hwrite, // AHB-Lite write flag
    input wire logic [2:0] hsize, // AHB-Lite transfer size
    input wire logic [31:0] hwdata, // AHB-Lite write data
    input wire logic hready, // AHB-Lite bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Slave response, always OKAY
    output logic [31:0] hrdata, // Read data
    output logic generatedCountClock, // One-cycle count enable
    output logic timerXCountEn, // Count enable offered to Timer X
    output logic serialIoCountEn, // Count enable offered to serial I/O
    output logic uart0CountEn, // Count enable offered to UART 0
    output logic uart1CountEn // Count enable offered to UART 1
);
    import scg_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Byte address of a register index
    function automatic logic [31:0] byteAddr(input scg_byte_t idx);
        byteAddr = {`SCG_HADDR_PAD, idx, 2'b00};
    endfunction

    // Address decode; anything else, or a non-word size, is unmapped
    function automatic scg_sel_t decodeSel(input logic [31:0] addr,
                                           input logic [2:0] size);
        decodeSel = SEL_NONE;
        if (size == `SCG_HSIZE_WORD) begin
            if (addr == byteAddr(`SCG_IDX_PRESCALE)) begin
                decodeSel = SEL_PRESCALE;
            end else if (addr == byteAddr(`SCG_IDX_DIVIDE)) begin
                decodeSel = SEL_DIVIDE;
            end else if (addr == byteAddr(`SCG_IDX_MODE)) begin
                decodeSel = SEL_MODE;
            end
        end
    endfunction

    // Read multiplexer; unmapped addresses read as zero
    function automatic scg_byte_t readMux(input scg_sel_t sel,
                                          input scg_byte_t cntA,
                                          input scg_byte_t cntB,
                                          input scg_byte_t modeVal);
        case (sel)
            SEL_PRESCALE: readMux = cntA;
            SEL_DIVIDE: readMux = cntB;
            SEL_MODE: readMux = modeVal;
            default: readMux = `SCG_RD_ZERO;
        endcase
    endfunction

    // ****************************************************************
    // State and internal signals
    // ****************************************************************
    scg_top_state_t s_q;
    scg_top_state_t s_d;

    logic addrValid;
    scg_sel_t addrSel;
    logic wrPrescale;
    logic wrDivide;
    logic wrMode;
    logic genEnable;
    logic stopA;
    logic wrCtrlA;
    logic wrCtrlB;
    logic countA;
    logic countB;
    logic underflowA;
    logic underflowB;
    scg_byte_t cntA;
    scg_byte_t cntB;
    scg_byte_t latchA;
    scg_byte_t latchB;

    // ****************************************************************
    // Mode bits
    // ****************************************************************
    assign wrCtrlA = s_q.mode[`SCG_BIT_WR_CTRL_A];
    assign stopA = s_q.mode[`SCG_BIT_STOP_CTRL_A];
    assign wrCtrlB = s_q.mode[`SCG_BIT_WR_CTRL_B];
    assign genEnable = s_q.mode[`SCG_BIT_GEN_OE];

    // ****************************************************************
    // Bus slave
    // ****************************************************************

    // Address phase is taken only while the bus is ready
    assign addrValid = hsel && hready && (htrans == `SCG_HTRANS_NONSEQ);
    assign addrSel = decodeSel(haddr, hsize);

    // Write strobes fire in the data phase, when hwdata stands
    assign wrPrescale = (s_q.busState == BUS_WRITE) && (s_q.busSel == SEL_PRESCALE);
    assign wrDivide = (s_q.busState == BUS_WRITE) && (s_q.busSel == SEL_DIVIDE);
    assign wrMode = (s_q.busState == BUS_WRITE) && (s_q.busSel == SEL_MODE);

    // One wait state on reads so a read after a write sees its effect
    assign hreadyout = (s_q.busState != BUS_RDWAIT);
    assign hresp = `SCG_HRESP_OKAY;
    assign hrdata = {`SCG_HRDATA_PAD, s_q.rdData};

    // ****************************************************************
    // Counter chain
    // ****************************************************************

    // First counter runs on every clock unless stopped or disabled
    assign countA = genEnable && !stopA;

    // Second counter sees the clocks on which the first did not underflow,
    // or every clock while the first is bypassed
    assign countB = genEnable && (stopA || !underflowA);

    scg_down_counter u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .countPulse(countA),
        .writeStrobe(wrPrescale),
        .writeData(hwdata[7:0]),
        .writeDeferred(wrCtrlA),
        .count(cntA),
        .latch(latchA),
        .underflow(underflowA)
    );

    scg_down_counter u_divide (
        .clk(clk),
        .rst_n(rst_n),
        .countPulse(countB),
        .writeStrobe(wrDivide),
        .writeData(hwdata[7:0]),
        .writeDeferred(wrCtrlB),
        .count(cntB),
        .latch(latchB),
        .underflow(underflowB)
    );

    // ****************************************************************
    // Next state: bus sequencing, mode register, output pulse
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        // Mode write; reserved bits stay zero
        if (wrMode) begin
            s_d.mode = hwdata[7:0] & `SCG_MODE_MASK;
        end
        // Output pulse per second-counter underflow, a flop not a clock net
        s_d.genPulse = genEnable && underflowB;
        case (s_q.busState)
            BUS_RDWAIT: begin
                // Sample after any preceding write has settled
                s_d.rdData = readMux(s_q.busSel, cntA, cntB, s_q.mode);
                s_d.busState = BUS_RDDONE;
            end
            BUS_IDLE, BUS_WRITE, BUS_RDDONE: begin
                if (addrValid) begin
                    s_d.busSel = addrSel;
                    s_d.busState = hwrite ? BUS_WRITE : BUS_RDWAIT;
                end else begin
                    s_d.busState = BUS_IDLE;
                end
            end
            default: begin
                s_d.busState = BUS_IDLE;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.mode <= `SCG_MODE_RST;
            s_q.busState <= BUS_IDLE;
            s_q.busSel <= SEL_NONE;
            s_q.rdData <= `SCG_RD_ZERO;
            s_q.genPulse <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Count-source routing
    // ****************************************************************

    // Every consumer gets the same registered pulse; each picks its source
    assign generatedCountClock = s_q.genPulse;
    assign timerXCountEn = s_q.genPulse;
    assign serialIoCountEn = s_q.genPulse;
    assign uart0CountEn = s_q.genPulse;
    assign uart1CountEn = s_q.genPulse;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Both latches take every write
    property p_latch_write;
        (wrPrescale |=> latchA == $past(hwdata[7:0])) and
        (wrDivide |=> latchB == $past(hwdata[7:0]));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("reload latch missed a write");

    // Zero plus a pulse reloads from the latch
    property p_reload;
        underflowA && !wrPrescale |=> cntA == $past(latchA);
    endproperty
    a_reload: assert property (p_reload)
        else $error("first counter did not reload at underflow");

    // Plain counting steps down by one
    property p_step;
        countA && !underflowA && !wrPrescale |=> cntA == $past(cntA) - `SCG_CNT_ONE;
    endproperty
    a_step: assert property (p_step)
        else $error("first counter did not step by one");

    // Second counter is starved on each first-counter underflow
    property p_gate;
        genEnable && !stopA |-> (countB == !underflowA);
    endproperty
    a_gate: assert property (p_gate)
        else $error("second counter gating wrong");

    // Output pulse follows each enabled second-counter underflow
    property p_pulse;
        genEnable && underflowB |=> generatedCountClock ##0 timerXCountEn;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("generated pulse missing after underflow");

    // Immediate first-counter write loads count next cycle
    property p_write_a;
        wrPrescale && !wrCtrlA |=> cntA == $past(hwdata[7:0]);
    endproperty
    a_write_a: assert property (p_write_a)
        else $error("immediate write to first counter not loaded");

    // Deferred write leaves an idle first counter untouched
    property p_defer_a;
        wrPrescale && wrCtrlA && !countA |=> $stable(cntA);
    endproperty
    a_defer_a: assert property (p_defer_a)
        else $error("deferred write changed first counter");

    // Immediate second-counter write loads count next cycle
    property p_write_b;
        wrDivide && !wrCtrlB |=> cntB == $past(hwdata[7:0]);
    endproperty
    a_write_b: assert property (p_write_b)
        else $error("immediate write to second counter not loaded");

    // Stop bit freezes the first counter and bypasses to the second
    property p_stop;
        genEnable && stopA && !wrPrescale |=> $stable(cntA) ##0 $past(countB);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop bit did not bypass first counter");

    // Disabled output freezes both counters and silences the pulse
    property p_disable;
        !genEnable && !wrPrescale && !wrDivide |=>
            $stable(cntA) && $stable(cntB) && !generatedCountClock;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled generator still counting");

    // A read answers after exactly one wait state
    property p_read;
        s_q.busState == BUS_RDWAIT |-> !hreadyout ##1 hreadyout;
    endproperty
    a_read: assert property (p_read)
        else $error("read wait state wrong");

    // Pulse never lasts without its cause one cycle before
    property p_one_cycle;
        generatedCountClock |-> $past(underflowB);
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("generated pulse without underflow");

    // Deferred second-counter write leaves an idle counter untouched
    property p_defer_b;
        wrDivide && wrCtrlB && !countB |=> $stable(cntB);
    endproperty
    a_defer_b: assert property (p_defer_b)
        else $error("deferred write changed second counter");

    // Output disable starves both counters, not only the output
    property p_stop_both;
        !genEnable |-> !countA && !countB;
    endproperty
    a_stop_both: assert property (p_stop_both)
        else $error("disabled generator still feeds a counter");

    // Every consumer sees the same pulse in the same cycle
    property p_route;
        (generatedCountClock == timerXCountEn) && (generatedCountClock == serialIoCountEn) &&
            (generatedCountClock == uart0CountEn) && (generatedCountClock == uart1CountEn);
    endproperty
    a_route: assert property (p_route)
        else $error("count enable differs between consumers");

    // An unmapped or non-word write changes no register
    property p_refuse;
        (s_q.busState == BUS_WRITE) && (s_q.busSel == SEL_NONE) |=>
            $stable(s_q.mode) && $stable(latchA) && $stable(latchB);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused write changed a register");

    // Read data stands until the next read samples it
    property p_rdata_hold;
        s_q.busState != BUS_RDWAIT |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed outside a read");

endmodule

//--- verilog/scg_defines.svh
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SCG_IDX_PRESCALE 8'h2D
`define SCG_IDX_DIVIDE 8'h2E
`define SCG_IDX_MODE 8'h2F

// ****************************************************************
// Reset values and counter figures
// ****************************************************************
`define SCG_CNT_RST 8'hFF
`define SCG_MODE_RST 8'h00
`define SCG_CNT_ZERO 8'h00
`define SCG_CNT_ONE 8'h01
`define SCG_RD_ZERO 8'h00

// ****************************************************************
// Mode register fields
// ****************************************************************
`define SCG_BIT_WR_CTRL_A 0
`define SCG_BIT_STOP_CTRL_A 1
`define SCG_BIT_WR_CTRL_B 2
`define SCG_BIT_GEN_OE 3
`define SCG_MODE_MASK 8'h0F

// ****************************************************************
// AHB-Lite encodings
// ****************************************************************
`define SCG_HTRANS_NONSEQ 2'h2
`define SCG_HSIZE_WORD 3'h2
`define SCG_HRESP_OKAY 1'h0
`define SCG_HRDATA_PAD 24'h000000
`define SCG_HADDR_PAD 22'h000000

`endif

//--- verilog/scg_down_counter.sv
`timescale 1ns/10ps
`include "scg_defines.svh"

module scg_down_counter (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic countPulse, // Count this cycle
    input wire logic writeStrobe, // Software write, one cycle
    input wire scg_pkg::scg_byte_t writeData, // Written value
    input wire logic writeDeferred, // 1: load count at next underflow only
    output scg_pkg::scg_byte_t count, // Current count
    output scg_pkg::scg_byte_t latch, // Reload latch
    output logic underflow // Count pulse seen at zero
);
    import scg_pkg::*;

    scg_ctr_state_t s_q;
    scg_ctr_state_t s_d;

    // Underflow is a same-cycle strobe so the next stage can gate on it
    assign underflow = countPulse && (s_q.count == `SCG_CNT_ZERO);
    assign count = s_q.count;
    assign latch = s_q.latch;

    // Next state: the write always lands in the latch, the count follows
    always_comb begin
        s_d = s_q;
        if (writeStrobe) begin
            s_d.latch = writeData;
        end
        if (underflow) begin
            // Reload, never wrap; a deferred write of this cycle is taken
            s_d.count = s_d.latch;
        end else if (countPulse) begin
            s_d.count = s_q.count - `SCG_CNT_ONE;
        end
        if (writeStrobe && !writeDeferred) begin
            s_d.count = writeData;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.count <= `SCG_CNT_RST;
            s_q.latch <= `SCG_CNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

//--- verilog/scg_pkg.sv
`include "scg_defines.svh"

package scg_pkg;

    // ****************************************************************
    // Shared types
    // ****************************************************************
    typedef logic [7:0] scg_byte_t;

    // Register selected by the address phase
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_PRESCALE = 2'b01,
        SEL_DIVIDE = 2'b10,
        SEL_MODE = 2'b11
    } scg_sel_t;

    // Bus slave data-phase state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_RDWAIT = 2'b10,
        BUS_RDDONE = 2'b11
    } scg_bus_t;

    // State of one down counter
    typedef struct packed {
        scg_byte_t count;
        scg_byte_t latch;
    } scg_ctr_state_t;

    // State of the generator top
    typedef struct packed {
        scg_byte_t mode;
        scg_bus_t busState;
        scg_sel_t busSel;
        scg_byte_t rdData;
        logic genPulse;
    } scg_top_state_t;

endpackage
